// ===== rtl/tmd_pkg.sv
// Package of constants and types for the transient motion detector
// Summary of operation
// - Axis event raised when filtered sample magnitude exceeds the threshold.
// - Bypass bit 0 picks filtered data, 1 picks unfiltered data.
// - Config bits 3,2,1 enable Z,Y,X; disabled axis never raises event.
// - With latch enable set, source bits change only on a new axis event or a read.
// - Reading the source register clears it, save a same-cycle sample's result, and drops the interrupt.
// - While latched, new events may add bits and update polarity; event bits hold until read.
// - Event active at bit 6 is one when any enabled axis event is set.
// - Source holds Z,Y,X event bits at 5,3,1; bit 7 reads zero.
// - Polarity bits 4,2,0 for Z,Y,X; one means negative.
// - Threshold is unsigned 7-bit in bits 6..0, 0.063 g steps, reset zero.
// - Threshold comparison spans up to 8 g at every full-scale range.
// - Low-noise setting limits the reachable threshold to 4 g.
// - Threshold bit 7 picks decrement (0) or clear (1) on lapse.
// - Count register at 0x20 holds the required debounce count.
// - Lapsed sample decrements counter to zero, or clears it per policy.
// - Each debounce step is one output sample period.
package tmd_pkg;
   // ****************************************************************
   // Register map (APB byte address is four times the index)
   // ****************************************************************
   localparam logic [7:0] TMD_IDX_CONFIG = 8'h1d;
   localparam logic [7:0] TMD_IDX_SOURCE = 8'h1e;
   localparam logic [7:0] TMD_IDX_THRESHOLD = 8'h1f;
   localparam logic [7:0] TMD_IDX_COUNT = 8'h20;
   localparam logic [7:0] TMD_IDX_IRQ_STATUS = 8'h30;
   localparam logic [7:0] TMD_IDX_IRQ_CLEAR = 8'h31;
   localparam logic [7:0] TMD_IDX_IRQ_ENABLE = 8'h32;
   localparam int TMD_ADDR_LSB = 2;
   localparam int TMD_IDX_W = 8;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int TMD_CFG_BYPASS = 0;
   localparam int TMD_CFG_X_EN = 1;
   localparam int TMD_CFG_LATCH = 4;
   localparam int TMD_CFG_W = 5;
   localparam int TMD_SRC_ACTIVE = 6;
   localparam int TMD_THS_POLICY = 7;
   localparam int TMD_THS_W = 7;
   localparam int TMD_AXES = 3;
   localparam int TMD_SAMPLE_W = 10;
   localparam logic [7:0] TMD_RESET_BYTE = 8'h00;
   // Threshold weight 0.063 g per step; sample LSB in 1/64 g units,
   // so threshold step maps to sample count scale of 4 (8 g span)
   localparam int TMD_THS_SHIFT = 2;
   // Low-noise cap: 4 g is threshold 63 steps
   localparam logic [6:0] TMD_THS_LOWNOISE_MAX = 7'h3f;
   // Sample period at 800 Hz: 1.25 ms in ns, clock 100 ns
   localparam int TMD_CLK_NS = 100;
   localparam int TMD_STEP_NS = 1250000;
   localparam int TMD_STEP_CYC = TMD_STEP_NS / TMD_CLK_NS;
   // Interrupt status bit
   localparam int TMD_IRQ_EVENT = 0;
endpackage

// ===== rtl/tmd_transient_detector.sv
// Transient motion detector core with APB register slave
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module tmd_transient_detector
   import tmd_pkg::*;
#(
   parameter int STEP_CYC = TMD_STEP_CYC
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Signed samples, 1/64 g per LSB, same clock domain
   input wire logic [TMD_SAMPLE_W-1:0] filt_x,
   input wire logic [TMD_SAMPLE_W-1:0] filt_y,
   input wire logic [TMD_SAMPLE_W-1:0] filt_z,
   input wire logic [TMD_SAMPLE_W-1:0] raw_x,
   input wire logic [TMD_SAMPLE_W-1:0] raw_y,
   input wire logic [TMD_SAMPLE_W-1:0] raw_z,
   // Low-noise setting from the control register
   input wire logic low_noise,
   // Outputs
   output logic irq,
   output logic sample_tick
);
   import tmd_pkg::*;

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [TMD_CFG_W-1:0] cfg_r;
   logic [7:0] ths_r;
   logic [7:0] count_r;
   logic [5:0] src_r;
   logic active_r;
   logic irq_sts_r;
   logic irq_en_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_r;
   logic tick_r;
   logic [23:0] div_r;
   logic [7:0] dbc_r [TMD_AXES];

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   wire [TMD_IDX_W-1:0] idx = paddr[TMD_ADDR_LSB+TMD_IDX_W-1:TMD_ADDR_LSB];
   wire aligned = (paddr[TMD_ADDR_LSB-1:0] == 2'h0);
   wire acc = psel && penable && !pready_r;
   wire hit_cfg = aligned && idx == TMD_IDX_CONFIG;
   wire hit_src = aligned && idx == TMD_IDX_SOURCE;
   wire hit_ths = aligned && idx == TMD_IDX_THRESHOLD;
   wire hit_cnt = aligned && idx == TMD_IDX_COUNT;
   wire hit_ists = aligned && idx == TMD_IDX_IRQ_STATUS;
   wire hit_iclr = aligned && idx == TMD_IDX_IRQ_CLEAR;
   wire hit_ien = aligned && idx == TMD_IDX_IRQ_ENABLE;
   wire mapped = hit_cfg | hit_src | hit_ths | hit_cnt | hit_ists
      | hit_iclr | hit_ien;
   wire wr = acc && pwrite && mapped;
   // Read-only and write-only registers refuse the wrong direction
   wire bad = !mapped || (pwrite && (hit_src || hit_ists))
      || (!pwrite && hit_iclr);
   wire src_rd = acc && !pwrite && hit_src;

   // Source byte: bit 7 zero, event active at bit 6
   // Source layout
   wire [7:0] src_byte = {1'b0, active_r, src_r};

   wire [31:0] rd_mux =
      hit_cfg ? {27'h0, cfg_r} :
      hit_src ? {24'h0, src_byte} :
      hit_ths ? {24'h0, ths_r} :
      hit_cnt ? {24'h0, count_r} :
      hit_ists ? {31'h0, irq_sts_r} :
      hit_ien ? {31'h0, irq_en_r} : 32'h0;

   // APB answer one cycle after the access phase starts
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end
      else
      begin
         pready_r <= acc;
         pslverr_r <= acc && bad;
         prdata_r <= (acc && !pwrite && !bad) ? rd_mux : 32'h0;
      end
   end

   // Control register writes, all fields reset to zero
   // Threshold field write
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cfg_r <= TMD_CFG_W'(TMD_RESET_BYTE);
         ths_r <= TMD_RESET_BYTE;
         count_r <= TMD_RESET_BYTE;
         irq_en_r <= 1'b0;
      end
      else if (wr)
      begin
         if (hit_cfg)
            cfg_r <= pwdata[TMD_CFG_W-1:0];
         if (hit_ths)
            ths_r <= pwdata[7:0];
         if (hit_cnt)
            count_r <= pwdata[7:0];
         if (hit_ien)
            irq_en_r <= pwdata[TMD_IRQ_EVENT];
      end
   end

   // ****************************************************************
   // Sample-rate divider
   // ****************************************************************
   // One step per output sample
   wire div_end = (div_r == 24'(STEP_CYC - 1));
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         div_r <= 24'h0;
         tick_r <= 1'b0;
      end
      else
      begin
         div_r <= div_end ? 24'h0 : div_r + 24'h1;
         tick_r <= div_end;
      end
   end

   // ****************************************************************
   // Threshold and per-axis comparison
   // ****************************************************************
   // Low-noise caps threshold at 4 g
   wire [6:0] ths_raw = ths_r[TMD_THS_W-1:0];
   wire [6:0] ths_eff = (low_noise && ths_raw > TMD_THS_LOWNOISE_MAX) ?
      TMD_THS_LOWNOISE_MAX : ths_raw;
   // Threshold scaled into 8 g sample span, independent of range
   wire [TMD_SAMPLE_W:0] ths_cmp = {2'b00, ths_eff, 2'b00};
   wire [2:0] axis_en = cfg_r[TMD_CFG_X_EN+2:TMD_CFG_X_EN];
   wire bypass = cfg_r[TMD_CFG_BYPASS];
   wire [TMD_SAMPLE_W-1:0] smp [TMD_AXES];
   assign smp[0] = bypass ? raw_x : filt_x;
   assign smp[1] = bypass ? raw_y : filt_y;
   assign smp[2] = bypass ? raw_z : filt_z;

   logic [2:0] over;
   logic [2:0] neg;
   logic [2:0] qual;
   genvar g;
   generate
      for (g = 0; g < TMD_AXES; g++)
      begin : g_axis
         wire sgn = smp[g][TMD_SAMPLE_W-1];
         wire [TMD_SAMPLE_W:0] mag = sgn ?
            (TMD_SAMPLE_W+1)'(-$signed({sgn, smp[g]})) :
            {1'b0, smp[g]};
         assign over[g] = mag > ths_cmp;
         assign neg[g] = sgn;
         // Qualified once counter reaches the count
         assign qual[g] = over[g] && (dbc_r[g] + 8'h1 >= count_r
            || dbc_r[g] == count_r);

         // Debounce counter, evaluated once per sample
         always_ff @(posedge ref_clk)
         begin
            if (sys_rst || !axis_en[g])
               dbc_r[g] <= 8'h0;
            else if (tick_r)
            begin
               if (over[g])
                  dbc_r[g] <= (dbc_r[g] >= count_r) ? count_r :
                     dbc_r[g] + 8'h1;
               else if (ths_r[TMD_THS_POLICY])
                  dbc_r[g] <= 8'h0;
               else if (dbc_r[g] != 8'h0)
                  dbc_r[g] <= dbc_r[g] - 8'h1;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Source register update
   // ****************************************************************
   // Disabled axes never raise events
   wire [2:0] hit = qual & axis_en;
   wire latch = cfg_r[TMD_CFG_LATCH];
   logic [5:0] src_nxt;
   always_comb
   begin
      src_nxt = src_r;
      for (int a = 0; a < TMD_AXES; a++)
      begin
         if (!latch)
         begin
            src_nxt[2*a+1] = hit[a];
            src_nxt[2*a] = hit[a] & neg[a];
         end
         // Frozen unless a new axis event arrives
         // New events add bits and update polarity
         else if (hit[a])
         begin
            src_nxt[2*a+1] = 1'b1;
            src_nxt[2*a] = neg[a];
         end
      end
   end

   // Active when any axis event set
   wire active_nxt = src_nxt[1] | src_nxt[3] | src_nxt[5];

   // Fresh sample result alone, used when a read clears the old bits
   wire [5:0] src_live = {hit[2], hit[2] & neg[2], hit[1],
      hit[1] & neg[1], hit[0], hit[0] & neg[0]};

   // A read in a sample cycle keeps only that sample's fresh result
   // Read outside a sample cycle clears every source bit
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         src_r <= 6'h0;
         active_r <= 1'b0;
      end
      else if (tick_r)
      begin
         src_r <= src_rd ? src_live : src_nxt;
         active_r <= src_rd ? |hit : active_nxt;
      end
      else if (src_rd)
      begin
         src_r <= 6'h0;
         active_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Interrupt status, clear and enable
   // ****************************************************************
   // Rising edge of event active sets the sticky bit; set wins
   logic active_d_r;
   wire ev_rise = active_r && !active_d_r;
   wire iclr = wr && hit_iclr && pwdata[TMD_IRQ_EVENT];
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         active_d_r <= 1'b0;
         irq_sts_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         active_d_r <= active_r;
         irq_sts_r <= ev_rise | (irq_sts_r & !iclr);
         // Pending condition also drops with the source read
         irq_r <= irq_en_r && irq_sts_r && active_r && !iclr && !src_rd;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
   assign sample_tick = tick_r;
endmodule

// ===== tb/tmd_checker.sv
// Bus and event checker for the transient detector
`timescale 1ns/100ps
module tmd_checker
   import tmd_pkg::*;
#(
   parameter int STEP_CYC = TMD_STEP_CYC
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Sample timing
   input wire logic sample_tick
);
   // ****************************************************************
   // Decode and tick spacing
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   // Index decode; upper address bits ignored by the slave
   wire acc = psel && penable && !pready;
   wire src = paddr[9:2] == TMD_IDX_SOURCE;
   wire known = paddr[9:2] inside {[8'h1d:8'h20], [8'h30:8'h32]};
   wire src_rd = pready && !pwrite && src;
   // Gap counter; the first tick after reset has no reference
   int unsigned gap_r;
   logic seen_r;
   always_ff @(posedge ref_clk)
   begin
      gap_r <= (sys_rst || sample_tick) ? 0 : gap_r + 1;
      seen_r <= sys_rst ? 1'b0 : (seen_r || sample_tick);
   end
   // ****************************************************************
   // Assertions
   // ****************************************************************
   one_wait_a: assert property (acc |=> pready)
      else $error("no answer one cycle after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   idle_data_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_err_a: assert property (acc && !known |=> pslverr)
      else $error("unmapped access not refused");
   src_write_err_a: assert property (acc && pwrite && src |=> pslverr)
      else $error("source write not refused");
   src_top_zero_a: assert property (src_rd |-> !prdata[7])
      else $error("source bit 7 set");
   src_active_a: assert property (
      src_rd |-> prdata[6] == (prdata[5] | prdata[3] | prdata[1]))
      else $error("active flag mismatch");
   tick_gap_a: assert property (
      sample_tick && seen_r |-> gap_r == STEP_CYC - 1)
      else $error("sample period wrong");
endmodule
bind tmd_transient_detector tmd_checker #(.STEP_CYC(STEP_CYC)) u_chk
(
   .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sample_tick(sample_tick)
);

// ===== tb/tmd_transient_detector_bench.sv
// Self-checking bench for the transient detector
`timescale 1ns/100ps
module tmd_transient_detector_bench;
   import tmd_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [9:0] fx = 10'h0, fy = 10'h0, fz = 10'h0;
   logic [9:0] rx = 10'h0, ry = 10'h0, rz = 10'h0;
   logic low_noise = 1'b0;
   logic irq;
   logic sample_tick;
   logic [31:0] rd;
   logic err;
   int miscompares = 0;
   int n_tests = 0;
   // Short sample period keeps the run brief
   tmd_transient_detector #(.STEP_CYC(8)) uut
   (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .filt_x(fx), .filt_y(fy),
      .filt_z(fz), .raw_x(rx), .raw_y(ry), .raw_z(rz),
      .low_noise(low_noise), .irq(irq), .sample_tick(sample_tick)
   );
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task end_sim;
      if (miscompares == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One bus transfer; request held until ready is sampled
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      // Ready, data and error are taken at the rising edge itself
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         miscompares++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
      chk({31'h0, err}, 32'h0);
   endtask
   task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h0);
      chk(rd, exp);
   endtask
   // Step past n sample ticks, returning on the sampling edge
   task go(input int n);
      repeat (n)
      begin
         do
            @(negedge ref_clk);
         while (sample_tick !== 1'b1);
         @(posedge ref_clk);
      end
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_regs;
      for (int i = 0; i < 4; i++)
         rd_chk(8'h1d + 8'(i), 32'h0);
      wr(8'h1d, 8'hff);
      rd_chk(8'h1d, 32'h1f);
      wr(8'h1f, 8'hff);
      rd_chk(8'h1f, 32'hff);
      wr(8'h20, 8'hff);
      rd_chk(8'h20, 32'hff);
      apb(1'b1, 8'h1e, 8'hff);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h10, 8'h0);
      chk({rd[30:0], err}, 32'h1);
   endtask
   task t_detect;
      wr(8'h1f, 8'h04);
      wr(8'h20, 8'h00);
      wr(8'h1d, 8'h0e);
      fx <= 10'd17;
      fy <= 10'h3ef;
      fz <= 10'd16;
      go(2);
      rd_chk(8'h1e, 32'h4e);
      wr(8'h1d, 8'h0a);
      go(2);
      rd_chk(8'h1e, 32'h42);
      wr(8'h1d, 8'h03);
      fx <= 10'd0;
      rx <= 10'h3ef;
      go(2);
      rd_chk(8'h1e, 32'h43);
      wr(8'h1d, 8'h02);
      go(2);
      rd_chk(8'h1e, 32'h00);
   endtask
   task t_latch;
      wr(8'h31, 8'h01);
      wr(8'h32, 8'h01);
      wr(8'h1d, 8'h12);
      fx <= 10'h3ef;
      go(2);
      chk({31'h0, irq}, 32'h1);
      fx <= 10'd0;
      go(2);
      rd_chk(8'h1e, 32'h43);
      rd_chk(8'h1e, 32'h00);
      chk({31'h0, irq}, 32'h0);
      rd_chk(8'h30, 32'h1);
      wr(8'h31, 8'h01);
      rd_chk(8'h30, 32'h0);
      wr(8'h32, 8'h00);
      fx <= 10'd17;
      go(2);
      chk({31'h0, irq}, 32'h0);
      wr(8'h31, 8'h01);
   endtask
   // Pattern over,over,under,over,over against a count of three
   task t_debounce;
      wr(8'h20, 8'h03);
      for (int p = 0; p < 2; p++)
      begin
         wr(8'h1f, p ? 8'h84 : 8'h04);
         fx <= 10'd0;
         go(4);
         apb(1'b0, 8'h1e, 8'h0);
         for (int i = 0; i < 5; i++)
         begin
            fx <= (i == 2) ? 10'd0 : 10'd17;
            go(1);
         end
         fx <= 10'd0;
         go(1);
         rd_chk(8'h1e, p ? 32'h0 : 32'h42);
      end
   endtask
   task cap(input logic ln, input logic [9:0] v, input logic [31:0] e);
      low_noise <= ln;
      fx <= 10'd0;
      go(2);
      apb(1'b0, 8'h1e, 8'h0);
      fx <= v;
      go(2);
      rd_chk(8'h1e, e);
   endtask
   // Clock, reset and test sequence
   initial
      forever #50 ref_clk = ~ref_clk;
   initial
   begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_detect();
      t_latch();
      t_debounce();
      wr(8'h20, 8'h00);
      wr(8'h1f, 8'h7f);
      cap(1'b1, 10'd300, 32'h42);
      cap(1'b0, 10'd300, 32'h0);
      cap(1'b0, 10'h1ff, 32'h42);
      end_sim();
   end
   // Watchdog far beyond the expected run length
   initial
   begin
      #2000000;
      miscompares++;
      end_sim();
   end
endmodule
